// >>> inc/sqr_pkg.sv
// Package with constants and types for the start-up and reset-cause block
//
// Functional notes
// R1: Optional power-up delay after power-on or brown-out
// R2: Run needs delay, oscillator timer, pin released
// R3: Start-up counters keep running while pin held
// R4: Late pin release starts run after ten cycles
// R5: Each reset updates cause flags; vector 0000h
// R6: Power-on flag zero until firmware writes one
// R7: Brown-out flag cleared by power-on or brown-out
// R8: Watchdog flag cleared by watchdog reset only
// R9: Pin flag cleared by pin reset, awake or asleep
// R10: Reset-instruction flag cleared by reset instruction
// R11: Overflow flag set by hardware, firmware clears
// R12: Underflow flag set by hardware, firmware clears
// R13: Stack resets only when stack reset enabled
// R14: Bit five reads as zero
// R15: Power-on sets timeout and power-down; watchdog clears timeout
// R16: Wake clears power-down, continues at next address
// R17: Interrupt wake with enable runs next, then 0004h
// R18: Power-on and brown-out initialise flags to defaults
// R19: Power-up delay starts after both releases
// R20: Low-power detector ORed into brown-out signal
// R21: Delay lengths are parameters
package sqr_pkg;
  localparam logic [11:0] ADDR_FLAGS    = 12'h000;
  localparam logic [11:0] ADDR_BORCTL   = 12'h004;
  localparam logic [11:0] ADDR_STATUS   = 12'h008;
  localparam logic [11:0] ADDR_WDTCTL   = 12'h00C;
  localparam int          ADDR_W        = 12;

  localparam int BIT_BROWN  = 0;
  localparam int BIT_POR    = 1;
  localparam int BIT_RINSTR = 2;
  localparam int BIT_PIN    = 3;
  localparam int BIT_WDT    = 4;
  localparam int BIT_UNF    = 6;
  localparam int BIT_OVF    = 7;
  localparam int BIT_PDOWN  = 3;
  localparam int BIT_TOUT   = 4;
  localparam int BIT_BRDY   = 0;
  localparam int BIT_BFS    = 6;
  localparam int BIT_SBEN   = 7;
  localparam int BIT_SWDT   = 0;

  localparam logic [7:0] FLAGS_MASK   = 8'hDF;
  localparam logic [7:0] FLAGS_POWER  = 8'h1C;
  localparam logic [7:0] BORCTL_RST   = 8'h80;
  localparam logic [7:0] BORCTL_WMASK = 8'hC0;
  localparam logic [7:0] WDTCTL_WMASK = 8'h3F;
  localparam logic [7:0] WDTCTL_RST   = 8'h16;
  localparam logic [7:0] STAT_WMASK   = 8'h07;

  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_INTR  = 16'h0004;

  localparam int PWRT_NS        = 64000;
  localparam int CLK_NS         = 20;
  localparam int PWRT_CYC       = (PWRT_NS + CLK_NS - 1) / CLK_NS;
  localparam int OST_CYC        = 1024;
  localparam int LATE_START_CYC = 10;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic por;
    logic brownout;
    logic lp_brownout;
    logic pin;
    logic wdt;
    logic rst_instr;
    logic stk_ovf;
    logic stk_unf;
  } sqr_evt_t;

  typedef struct packed {
    logic wake_wdt;
    logic wake_intr;
    logic pin_sleep;
  } sqr_wake_t;

  typedef enum logic [3:0] {
    ST_PWRT = 4'b0001,
    ST_OST  = 4'b0010,
    ST_PIN  = 4'b0100,
    ST_RUN  = 4'b1000
  } sqr_state_t;
endpackage : sqr_pkg

// >>> rtl/sqr_top.sv
// Start-up sequencer and reset-cause registers with AHB-Lite access
`timescale 1ns/1ps
module sqr_top #(
  parameter int PWRT_CYCLES = sqr_pkg::PWRT_CYC, // [R21]
  parameter int OST_CYCLES  = sqr_pkg::OST_CYC,
  parameter int CNT_W       = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire sqr_pkg::sqr_evt_t evt,
  input  wire sqr_pkg::sqr_wake_t wake,
  input  wire logic              powerup_delay_enable,
  input  wire logic              osc_needs_ost,
  input  wire logic              pin_reset_enable,
  input  wire logic              external_reset_pin,
  input  wire logic              stack_reset_enable,
  input  wire logic              global_interrupt_enable,
  input  wire logic              brownout_ready,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   core_run,
  output logic                   pc_load,
  output logic [15:0]            pc_value,
  output logic                   software_brownout_enable,
  output logic                   brownout_fast_start,
  output logic [4:0]             watchdog_prescale_select,
  output logic                   software_watchdog_enable
);
  import sqr_pkg::*;

  sqr_state_t        state_ff;
  sqr_state_t        nxt_state;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  nxt_cnt;
  logic [7:0]        flags_ff;
  logic [7:0]        nxt_flags;
  logic [1:0]        stat_ff;
  logic [7:0]        stat_lo_ff;
  logic [7:0]        borctl_ff;
  logic [7:0]        wdtctl_ff;
  logic              pwrt_done_ff;
  logic              ost_done_ff;
  logic              wr_pend_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic              intr_pend_ff;

  // Reset sources
  wire brown     = evt.brownout | evt.lp_brownout;                 // [R20]
  wire stk_rst   = stack_reset_enable & (evt.stk_ovf | evt.stk_unf); // [R13]
  wire power_rst = evt.por | brown;
  wire true_rst  = power_rst | evt.pin | evt.wdt | evt.rst_instr | stk_rst | wake.pin_sleep; // [R5] [R9]
  wire pin_held  = pin_reset_enable & ~external_reset_pin;
  wire any_wake  = wake.wake_wdt | wake.wake_intr | wake.pin_sleep;

  // Bus decode
  wire              addr_ph = hsel & hready & htrans[1];
  wire [ADDR_W-1:0] a_off   = haddr[ADDR_W-1:0];
  wire              wr_now  = wr_pend_ff;
  wire [7:0]        wd      = hwdata[7:0];
  wire w_flags  = wr_now & (wr_addr_ff == ADDR_FLAGS);
  wire w_borctl = wr_now & (wr_addr_ff == ADDR_BORCTL);
  wire w_stat   = wr_now & (wr_addr_ff == ADDR_STATUS);
  wire w_wdtctl = wr_now & (wr_addr_ff == ADDR_WDTCTL);
  wire [7:0] status_rd = {3'b000, stat_ff[1], stat_ff[0], stat_lo_ff[2:0]};
  wire [7:0] borctl_rd = {borctl_ff[7:6], 5'b00000, brownout_ready};
  wire [7:0] rd_sel = (a_off == ADDR_FLAGS)  ? (flags_ff & FLAGS_MASK) :  // [R14]
                      (a_off == ADDR_BORCTL) ? borctl_rd :
                      (a_off == ADDR_STATUS) ? status_rd :
                      (a_off == ADDR_WDTCTL) ? wdtctl_ff : 8'h00;

  // Counters done flags
  wire pwrt_need = powerup_delay_enable & ~pwrt_done_ff;           // [R1]
  wire ost_need  = osc_needs_ost & ~ost_done_ff;
  wire cnt_end   = (cnt_ff == '0);

  // Start-up sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_PWRT: begin
        // Counts regardless of the pin
        if (!pwrt_need || cnt_end) begin                           // [R3] [R19]
          nxt_state = ST_OST;
          nxt_cnt   = CNT_W'(OST_CYCLES - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ST_OST: begin
        if (!ost_need || cnt_end) begin                            // [R3]
          nxt_state = ST_PIN;
          nxt_cnt   = CNT_W'(LATE_START_CYC - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ST_PIN: begin
        if (pin_held) begin
          nxt_cnt = CNT_W'(LATE_START_CYC - 1);
        end else if (cnt_end) begin                                // [R2] [R4]
          nxt_state = ST_RUN;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ST_RUN: begin
        if (pin_held) begin
          nxt_state = ST_PIN;
          nxt_cnt   = CNT_W'(LATE_START_CYC - 1);
        end
      end
      default: begin
        nxt_state = ST_PWRT;
        nxt_cnt   = CNT_W'(PWRT_CYCLES - 1);
      end
    endcase
    if (power_rst) begin
      nxt_state = ST_PWRT;
      nxt_cnt   = CNT_W'(PWRT_CYCLES - 1);
    end else if (true_rst && state_ff == ST_RUN) begin
      nxt_state = ST_PIN;
      nxt_cnt   = CNT_W'(LATE_START_CYC - 1);
    end
  end

  // Cause flags; hardware events win over firmware writes
  always_comb begin
    nxt_flags = flags_ff;
    if (w_flags) begin
      nxt_flags = wd & FLAGS_MASK;
    end
    if (power_rst) begin
      nxt_flags[BIT_OVF] = 1'b0;                                   // [R18]
      nxt_flags[BIT_UNF] = 1'b0;
      nxt_flags[BIT_WDT] = 1'b1;
      nxt_flags[BIT_PIN] = 1'b1;
      nxt_flags[BIT_RINSTR] = 1'b1;
      nxt_flags[BIT_BROWN]  = 1'b0;                                // [R7]
      if (evt.por) begin
        nxt_flags[BIT_POR] = 1'b0;                                 // [R6]
      end
    end else begin
      if (evt.wdt) begin
        nxt_flags[BIT_WDT] = 1'b0;                                 // [R8]
      end
      if (evt.pin || wake.pin_sleep) begin
        nxt_flags[BIT_PIN] = 1'b0;                                 // [R9]
      end
      if (evt.rst_instr) begin
        nxt_flags[BIT_RINSTR] = 1'b0;                              // [R10]
      end
      if (evt.stk_ovf) begin
        nxt_flags[BIT_OVF] = 1'b1;                                 // [R11]
      end
      if (evt.stk_unf) begin
        nxt_flags[BIT_UNF] = 1'b1;                                 // [R12]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= ST_PWRT;
      cnt_ff   <= CNT_W'(PWRT_CYCLES - 1);
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn || power_rst) begin
      pwrt_done_ff <= 1'b0;
      ost_done_ff  <= 1'b0;
    end else begin
      if (state_ff == ST_OST) begin
        pwrt_done_ff <= 1'b1;
      end
      if (state_ff == ST_PIN) begin
        ost_done_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flags_ff <= FLAGS_POWER;
    end else begin
      flags_ff <= nxt_flags;                                       // [R5]
    end
  end

  // Timeout and power-down bits
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stat_ff <= 2'b11;
    end else if (evt.por) begin
      stat_ff <= 2'b11;                                            // [R15]
    end else if (brown) begin
      stat_ff <= 2'b11;
    end else if (evt.wdt) begin
      stat_ff[1] <= 1'b0;                                          // [R15]
    end else if (wake.wake_wdt) begin
      stat_ff <= 2'b00;                                            // [R16]
    end else if (wake.wake_intr || wake.pin_sleep) begin
      stat_ff <= 2'b10;                                            // [R16]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stat_lo_ff <= 8'h00;
    end else if (w_stat) begin
      stat_lo_ff <= wd & STAT_WMASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      borctl_ff <= BORCTL_RST;
      wdtctl_ff <= WDTCTL_RST;
    end else begin
      if (w_borctl) begin
        borctl_ff <= wd & BORCTL_WMASK;
      end
      if (w_wdtctl) begin
        wdtctl_ff <= wd & WDTCTL_WMASK;
      end
    end
  end

  // Program counter loads
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pc_load      <= 1'b0;
      pc_value     <= VEC_RESET;
      intr_pend_ff <= 1'b0;
    end else begin
      pc_load      <= 1'b0;
      intr_pend_ff <= 1'b0;
      if (true_rst) begin
        pc_load  <= 1'b1;                                          // [R5] [R13]
        pc_value <= VEC_RESET;
      end else if (intr_pend_ff) begin
        pc_load  <= 1'b1;                                          // [R17]
        pc_value <= VEC_INTR;
      end else if (wake.wake_intr && global_interrupt_enable) begin
        intr_pend_ff <= 1'b1;                                      // [R17]
      end
    end
  end

  // AHB-Lite slave, zero wait states
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pend_ff <= addr_ph & hwrite;
      wr_addr_ff <= a_off;
      if (addr_ph && !hwrite) begin
        hrdata <= {24'h000000, rd_sel};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      core_run                 <= 1'b0;
      software_brownout_enable <= BORCTL_RST[BIT_SBEN];
      brownout_fast_start      <= BORCTL_RST[BIT_BFS];
      watchdog_prescale_select <= WDTCTL_RST[5:1];
      software_watchdog_enable <= WDTCTL_RST[BIT_SWDT];
    end else begin
      core_run                 <= (nxt_state == ST_RUN) & ~any_wake; // [R2]
      software_brownout_enable <= borctl_ff[BIT_SBEN];
      brownout_fast_start      <= borctl_ff[BIT_BFS];
      watchdog_prescale_select <= wdtctl_ff[5:1];
      software_watchdog_enable <= wdtctl_ff[BIT_SWDT];
    end
  end

  a_late_start: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
    (state_ff == ST_PIN && !pin_held && cnt_end && !true_rst) |=> state_ff == ST_RUN)
    else $error("run did not follow late release");
  a_pin_holds: assert property (@(posedge ref_clk) disable iff (!resetn) // [R2]
    (pin_held && !power_rst) |=> state_ff != ST_RUN)
    else $error("ran with pin held");
  a_bit_five: assert property (@(posedge ref_clk) disable iff (!resetn) // [R14]
    (addr_ph && !hwrite && a_off == ADDR_FLAGS) |=> hrdata[5] == 1'b0)
    else $error("bit five not zero");
  a_ovf_set: assert property (@(posedge ref_clk) disable iff (!resetn) // [R11]
    (evt.stk_ovf && !power_rst) |=> flags_ff[BIT_OVF])
    else $error("overflow flag not set");
  a_unf_set: assert property (@(posedge ref_clk) disable iff (!resetn) // [R12]
    (evt.stk_unf && !power_rst) |=> flags_ff[BIT_UNF])
    else $error("underflow flag not set");
  a_wdt_clr: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8]
    (evt.wdt && !power_rst) |=> !flags_ff[BIT_WDT] && !stat_ff[1])
    else $error("watchdog cause not recorded");
  a_por_init: assert property (@(posedge ref_clk) disable iff (!resetn) // [R18]
    evt.por |=> flags_ff[7:1] == 7'b0001110 && stat_ff == 2'b11)
    else $error("power-on defaults wrong");
  a_brown_clr: assert property (@(posedge ref_clk) disable iff (!resetn) // [R20]
    evt.lp_brownout |=> !flags_ff[BIT_BROWN])
    else $error("low-power brown-out missed");
  a_intr_vec: assert property (@(posedge ref_clk) disable iff (!resetn) // [R17]
    (wake.wake_intr && global_interrupt_enable && !true_rst && !intr_pend_ff) ##1 !true_rst
      |=> pc_load && pc_value == VEC_INTR)
    else $error("interrupt vector not loaded");
  a_reset_vec: assert property (@(posedge ref_clk) disable iff (!resetn) // [R5]
    true_rst |=> pc_load && pc_value == VEC_RESET)
    else $error("reset vector not loaded");
  a_stk_gate: assert property (@(posedge ref_clk) disable iff (!resetn) // [R13]
    (!true_rst && !intr_pend_ff) |=> !pc_load)
    else $error("program counter loaded without cause");
  a_ri_clr: assert property (@(posedge ref_clk) disable iff (!resetn) // [R10]
    (evt.rst_instr && !power_rst) |=> !flags_ff[BIT_RINSTR])
    else $error("reset instruction cause not recorded");
  a_pin_clr: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
    ((evt.pin || wake.pin_sleep) && !power_rst) |=> !flags_ff[BIT_PIN])
    else $error("pin reset cause not recorded");
  a_wake_pdown: assert property (@(posedge ref_clk) disable iff (!resetn) // [R16]
    (any_wake && !power_rst && !evt.wdt) |=> !stat_ff[0])
    else $error("wake left power-down bit set");
  a_brown_init: assert property (@(posedge ref_clk) disable iff (!resetn) // [R7]
    (brown && !evt.por) |=> flags_ff[7:6] == 2'b00 && !flags_ff[BIT_BROWN] && stat_ff == 2'b11)
    else $error("brown-out defaults wrong");
  a_power_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // [R19]
    power_rst |=> state_ff == ST_PWRT && !core_run)
    else $error("start-up not restarted by power reset");
endmodule : sqr_top

// >>> tb/sqr_src_model.sv
// Reset-source model driving event pulses and the reset pin
`timescale 1ns/1ps
module sqr_src_model (
  input  wire sqr_pkg::sqr_evt_t  evt_req,
  input  wire sqr_pkg::sqr_wake_t wake_req,
  input  wire logic               pin_hold,
  output sqr_pkg::sqr_evt_t       evt,
  output sqr_pkg::sqr_wake_t      wake,
  output logic                    external_reset_pin
);
  import sqr_pkg::*;
  // Weak pull-up unless held low
  assign external_reset_pin = ~pin_hold;
  // Detector outputs kept apart, the block merges them
  assign evt  = evt_req;
  assign wake = wake_req;
endmodule : sqr_src_model

// >>> tb/sqr_top_tb.sv
// Self-checking testbench for the start-up and reset-cause block
`timescale 1ns/1ps
module sqr_top_tb;
  import sqr_pkg::*;
  logic        ref_clk, resetn, hsel, hwrite, hold, pwrt_en, ost_en, pin_en, stk_en, int_en, brdy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, core_run, pc_load, sw_brown_en, bfs, sw_wdt_en, pin;
  logic [15:0] pc_value;
  logic [4:0]  wps;
  logic [7:0]  fl;
  sqr_evt_t    er, evt;
  sqr_wake_t   wr, wake;
  int          fails, compares;

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  sqr_src_model i_sqr_src_model (.evt_req(er), .wake_req(wr), .pin_hold(hold), .evt(evt), .wake(wake),
    .external_reset_pin(pin));

  sqr_top #(.PWRT_CYCLES(4), .OST_CYCLES(4)) i_sqr_top (.ref_clk(ref_clk), .resetn(resetn), .evt(evt),
    .wake(wake), .powerup_delay_enable(pwrt_en), .osc_needs_ost(ost_en), .pin_reset_enable(pin_en),
    .external_reset_pin(pin), .stack_reset_enable(stk_en), .global_interrupt_enable(int_en),
    .brownout_ready(brdy), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .core_run(core_run), .pc_load(pc_load), .pc_value(pc_value), .software_brownout_enable(sw_brown_en),
    .brownout_fast_start(bfs), .watchdog_prescale_select(wps), .software_watchdog_enable(sw_wdt_en));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr8(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h000000, d}, q);
  endtask : wr8

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(q & m, exp);
  endtask : rd

  task automatic ev(input sqr_evt_t e, input sqr_wake_t w, input logic ld, input logic [15:0] pc);
    logic        seen;
    logic [15:0] pcv;
    seen = 1'b0;
    pcv  = 16'h0000;
    @(posedge ref_clk);
    er <= e;
    wr <= w;
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      er <= '0;
      wr <= '0;
      if (pc_load === 1'b1) begin
        seen = 1'b1;
        pcv  = pc_value;
      end
    end
    chk({31'h0, seen}, {31'h0, ld});
    chk({16'h0, pcv}, ld ? {16'h0, pc} : 32'h0);
  endtask : ev

  task automatic s_reset;
    rd(ADDR_FLAGS, 32'hFFFFFFFF, 32'h0000001C);
    rd(ADDR_STATUS, 32'h18, 32'h18);
    rd(ADDR_BORCTL, 32'hFFFFFFFF, 32'h00000081);
    rd(ADDR_WDTCTL, 32'hFFFFFFFF, 32'h00000016);
    rd(12'h010, 32'hFFFFFFFF, 32'h00000000);
  endtask : s_reset

  task automatic s_start;
    int n;
    n = 0;
    repeat (30) @(posedge ref_clk);
    chk({31'h0, core_run}, 32'h0);
    hold <= 1'b0;
    while (core_run !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, n >= 10 && n <= 12}, 32'h1);
  endtask : s_start

  task automatic s_cause;
    logic [7:0] code [3] = '{8'h08, 8'h10, 8'h04};
    int         bitn [3] = '{BIT_WDT, BIT_PIN, BIT_RINSTR};
    wr8(ADDR_FLAGS, 8'hFF);
    fl = 8'hDF;
    rd(ADDR_FLAGS, 32'hFF, {24'h0, fl});
    for (int i = 0; i < 3; i++) begin
      ev(code[i], '0, 1'b1, VEC_RESET);
      fl[bitn[i]] = 1'b0;
      rd(ADDR_FLAGS, 32'hFF, {24'h0, fl});
    end
    rd(ADDR_STATUS, 32'h10, 32'h00);
  endtask : s_cause

  task automatic s_stack;
    wr8(ADDR_FLAGS, 8'h00);
    fl = 8'h00;
    stk_en <= 1'b0;
    ev(8'h02, '0, 1'b0, VEC_RESET);
    fl[BIT_OVF] = 1'b1;
    rd(ADDR_FLAGS, 32'hFF, {24'h0, fl});
    stk_en <= 1'b1;
    ev(8'h01, '0, 1'b1, VEC_RESET);
    fl[BIT_UNF] = 1'b1;
    rd(ADDR_FLAGS, 32'hFF, {24'h0, fl});
    wr8(ADDR_FLAGS, 8'h03);
    rd(ADDR_FLAGS, 32'hFF, 32'h03);
  endtask : s_stack

  task automatic s_power;
    logic [7:0] code [3] = '{8'h20, 8'h40, 8'h80};
    logic [7:0] want [3] = '{8'h1E, 8'h1E, 8'h1C};
    for (int i = 0; i < 3; i++) begin
      wr8(ADDR_FLAGS, 8'h03);
      ev(code[i], '0, 1'b1, VEC_RESET);
      rd(ADDR_FLAGS, 32'hFF, {24'h0, want[i]});
      rd(ADDR_STATUS, 32'h18, 32'h18);
    end
  endtask : s_power

  task automatic s_wake;
    ev('0, 3'b010, 1'b0, VEC_RESET);
    int_en <= 1'b1;
    ev('0, 3'b010, 1'b1, VEC_INTR);
    rd(ADDR_STATUS, 32'h18, 32'h10);
    ev('0, 3'b100, 1'b0, VEC_RESET);
    rd(ADDR_STATUS, 32'h18, 32'h00);
    ev('0, 3'b001, 1'b1, VEC_RESET);
    rd(ADDR_STATUS, 32'h18, 32'h10);
    rd(ADDR_FLAGS, 32'h08, 32'h00);
  endtask : s_wake

  task automatic s_ctrl;
    wr8(ADDR_BORCTL, 8'h7F);
    rd(ADDR_BORCTL, 32'hFF, 32'h41);
    wr8(ADDR_WDTCTL, 8'hFF);
    rd(ADDR_WDTCTL, 32'hFF, 32'h3F);
    wr8(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 32'h07, 32'h07);
    wr8(12'h010, 8'hFF);
    rd(12'h010, 32'hFFFFFFFF, 32'h0);
    chk({24'h0, sw_brown_en, bfs, sw_wdt_en, wps}, {24'h0, 3'b011, 5'h1F});
    chk({30'h0, hreadyout, hresp}, 32'h2);
  endtask : s_ctrl

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (8000) @(posedge ref_clk);
    fails++;
    give_verdict();
  end

  initial begin
    {resetn, hsel, hwrite, stk_en, int_en} = '0;
    {hold, pwrt_en, ost_en, pin_en, brdy} = 5'h1F;
    {haddr, hwdata, htrans, hsize, er, wr} = '0;
    fails    = 0;
    compares = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    s_reset();
    s_start();
    s_cause();
    s_stack();
    s_power();
    s_wake();
    s_ctrl();
    give_verdict();
  end
endmodule : sqr_top_tb
